// file: common/hcs_pkg.sv
// Package: constants and carrier types for the hub configuration strap selector
package hcs_pkg;
    // Configuration method codes, {sel_hi, sel_lo}
    typedef enum logic [1:0] {
        HCS_M_RESERVED = 2'h0,
        HCS_M_SMBUS    = 2'h1,
        HCS_M_DEFAULT  = 2'h2,
        HCS_M_EEPROM   = 2'h3
    } hcs_method_t;

    localparam logic [6:0] SMB_SLAVE_ADDR = 7'h2C;
    localparam logic [1:0] METHOD_RST = 2'h0;
    localparam int CLK_FREQ_HZ = 10000000;
    localparam int RST_MIN_NS = 1000;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_FREQ_HZ;
    localparam int RST_MIN_CYC_I = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RST_MIN_CYC = 4'(RST_MIN_CYC_I < 1 ? 1 : RST_MIN_CYC_I);
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h1;

    typedef enum logic [1:0] {
        HCS_S_RESET  = 2'h0,
        HCS_S_SAMPLE = 2'h1,
        HCS_S_RUN    = 2'h2
    } hcs_state_t;

    // Strap pins as sampled together
    typedef struct packed {
        logic sel_hi;
        logic sel_lo;
        logic ext_clk;
        logic local_pwr;
    } hcs_straps_t;

    // Decoded method and power outputs
    typedef struct packed {
        logic smbus_en;
        logic default_en;
        logic eeprom_en;
        logic reserved;
        logic self_powered;
        logic ext_clock;
        logic serial_clk_en;
    } hcs_cfg_t;
endpackage

// file: rtl/hcs_decode.sv
// Decoder from latched straps to configuration enables
`timescale 1ns/10ps
`default_nettype none
module hcs_decode (
    input wire logic CLK_I,                       // System clock
    input wire logic NRST_I,                      // Async reset, active low
    input wire logic load_i,                      // Refresh output from straps
    input var hcs_pkg::hcs_straps_t straps_i,     // Latched straps
    output var hcs_pkg::hcs_cfg_t cfg_o           // Registered decode
);
    typedef struct packed {
        hcs_pkg::hcs_cfg_t cfg;
    } hcs_dec_state_t;

    hcs_dec_state_t st_ff;
    hcs_dec_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (load_i)
        begin
            nxt_st.cfg.smbus_en = ({straps_i.sel_hi, straps_i.sel_lo} == hcs_pkg::HCS_M_SMBUS);
            nxt_st.cfg.default_en = ({straps_i.sel_hi, straps_i.sel_lo} == hcs_pkg::HCS_M_DEFAULT);
            nxt_st.cfg.eeprom_en = ({straps_i.sel_hi, straps_i.sel_lo} == hcs_pkg::HCS_M_EEPROM);
            nxt_st.cfg.reserved = ({straps_i.sel_hi, straps_i.sel_lo} == hcs_pkg::HCS_M_RESERVED);
            // Power detect pin is latched in every mode; the top passes it on only in the default mode
            nxt_st.cfg.self_powered = straps_i.local_pwr;
            nxt_st.cfg.ext_clock = straps_i.ext_clk;
            // Shared clock line goes to the serial engine only in a serial mode
            nxt_st.cfg.serial_clk_en = straps_i.sel_lo;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign cfg_o = st_ff.cfg;
endmodule
`default_nettype wire

// file: rtl/hcs_top.sv
// Top: strap sampling at reset release and configuration method selection
`timescale 1ns/10ps
`default_nettype none
module hcs_top (
    input wire logic CLK_I,                 // 10 MHz system clock
    input wire logic NRST_I,                // Async reset, active low
    input wire logic SCL_I,                 // Serial clock pin level, also low select strap
    input wire logic CONFIG_METHOD_SEL_HI_I, // High select strap
    input wire logic EXT_CLOCK_SELECT_I,    // External clock select strap
    input wire logic LOCAL_POWER_DETECT_I,  // Local power detect
    output logic [1:0] METHOD_O,            // Latched method code
    output logic CFG_VALID_O,               // Method latched and decoded
    output logic SMBUS_SLAVE_EN_O,          // Management-bus slave mode
    output logic [6:0] SMB_ADDR_O,          // Slave address in use
    output logic DEFAULT_CFG_EN_O,          // Internal default mode
    output logic EEPROM_EN_O,               // EEPROM load mode
    output logic METHOD_RESERVED_O,         // Reserved code was strapped
    output logic SELF_POWERED_O,            // Self powered status
    output logic EXT_CLOCK_O,               // Oscillator input takes CMOS clock
    output logic SERIAL_SCL_O,              // Serial clock to the serial engine
    output logic RST_TOO_SHORT_O            // Reset-too-short flag, tied low; pulse width is not measured
);
    typedef struct packed {
        hcs_pkg::hcs_state_t state;
        hcs_pkg::hcs_straps_t straps;
        logic [1:0] settle;
        logic [3:0] low_cnt;
        logic short_rst;
        logic scl;
        logic valid;
    } hcs_top_state_t;

    hcs_top_state_t st_ff;
    hcs_top_state_t nxt_st;
    hcs_pkg::hcs_cfg_t cfg;
    logic load;

    always_comb
    begin
        nxt_st = st_ff;
        load = 1'b0;
        case (st_ff.state)
            hcs_pkg::HCS_S_RESET:
            begin
                // Give the straps one cycle after release before sampling
                if (st_ff.settle + 2'h1 == hcs_pkg::STRAP_SETTLE_CYC)
                    nxt_st.state = hcs_pkg::HCS_S_SAMPLE;
                else
                    nxt_st.settle = st_ff.settle + 2'h1;
            end
            hcs_pkg::HCS_S_SAMPLE:
            begin
                nxt_st.straps.sel_lo = SCL_I;
                nxt_st.straps.sel_hi = CONFIG_METHOD_SEL_HI_I;
                nxt_st.straps.ext_clk = EXT_CLOCK_SELECT_I;
                nxt_st.straps.local_pwr = LOCAL_POWER_DETECT_I;
                nxt_st.state = hcs_pkg::HCS_S_RUN;
                load = 1'b1;
            end
            hcs_pkg::HCS_S_RUN:
            begin
                // Straps stay frozen; only reset leaves this state
                nxt_st.state = hcs_pkg::HCS_S_RUN;
                nxt_st.valid = 1'b1;
            end
            default:
                nxt_st.state = hcs_pkg::HCS_S_RESET;
        endcase
        // After sampling the pin is plain serial clock
        nxt_st.scl = (st_ff.state == hcs_pkg::HCS_S_RUN) & SCL_I;
    end

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    hcs_decode u_dec (
        .CLK_I(CLK_I),
        .NRST_I(NRST_I),
        .load_i(load),
        .straps_i(nxt_st.straps),
        .cfg_o(cfg)
    );

    // Output registers
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            METHOD_O <= hcs_pkg::METHOD_RST;
            CFG_VALID_O <= 1'b0;
            SMBUS_SLAVE_EN_O <= 1'b0;
            SMB_ADDR_O <= 7'h00;
            DEFAULT_CFG_EN_O <= 1'b0;
            EEPROM_EN_O <= 1'b0;
            METHOD_RESERVED_O <= 1'b0;
            SELF_POWERED_O <= 1'b0;
            EXT_CLOCK_O <= 1'b0;
            SERIAL_SCL_O <= 1'b0;
            RST_TOO_SHORT_O <= 1'b0;
        end
        else
        begin
            METHOD_O <= {st_ff.straps.sel_hi, st_ff.straps.sel_lo};
            CFG_VALID_O <= st_ff.valid;
            SMBUS_SLAVE_EN_O <= cfg.smbus_en & st_ff.valid;
            SMB_ADDR_O <= cfg.smbus_en ? hcs_pkg::SMB_SLAVE_ADDR : 7'h00;
            DEFAULT_CFG_EN_O <= cfg.default_en & st_ff.valid;
            EEPROM_EN_O <= cfg.eeprom_en & st_ff.valid;
            METHOD_RESERVED_O <= cfg.reserved & st_ff.valid;
            // Serial modes get power status by download, default mode from the pin
            SELF_POWERED_O <= cfg.default_en & cfg.self_powered;
            EXT_CLOCK_O <= cfg.ext_clock;
            SERIAL_SCL_O <= st_ff.scl & cfg.serial_clk_en;
            RST_TOO_SHORT_O <= 1'b0;
        end
    end

    property p_method_frozen;
        @(posedge CLK_I) disable iff (!NRST_I)
        $past(CFG_VALID_O) & CFG_VALID_O |-> $stable(METHOD_O);
    endproperty
    a_method_frozen: assert property (p_method_frozen) else $error("method changed");

    property p_onehot;
        @(posedge CLK_I) disable iff (!NRST_I)
        CFG_VALID_O |-> $onehot({SMBUS_SLAVE_EN_O, DEFAULT_CFG_EN_O, EEPROM_EN_O,
            METHOD_RESERVED_O});
    endproperty
    a_onehot: assert property (p_onehot) else $error("method not one-hot");

    property p_smbus;
        @(posedge CLK_I) disable iff (!NRST_I)
        SMBUS_SLAVE_EN_O |-> METHOD_O == 2'h1 && SMB_ADDR_O == 7'h2C;
    endproperty
    a_smbus: assert property (p_smbus) else $error("smbus decode wrong");

    property p_default;
        @(posedge CLK_I) disable iff (!NRST_I)
        CFG_VALID_O |-> DEFAULT_CFG_EN_O == (METHOD_O == 2'h2);
    endproperty
    a_default: assert property (p_default) else $error("default decode wrong");

    property p_eeprom;
        @(posedge CLK_I) disable iff (!NRST_I)
        CFG_VALID_O |-> EEPROM_EN_O == (METHOD_O == 2'h3);
    endproperty
    a_eeprom: assert property (p_eeprom) else $error("eeprom decode wrong");

    property p_valid_time;
        @(posedge CLK_I) disable iff (!NRST_I)
        $rose(NRST_I) |-> (!CFG_VALID_O) [*4] ##1 CFG_VALID_O;
    endproperty
    a_valid_time: assert property (p_valid_time) else $error("method not ready in time");

    property p_scl_gate;
        @(posedge CLK_I) disable iff (!NRST_I)
        SERIAL_SCL_O |-> CFG_VALID_O && METHOD_O[0];
    endproperty
    a_scl_gate: assert property (p_scl_gate) else $error("serial clock leaked");

    property p_local_power_detect;
        @(posedge CLK_I) disable iff (!NRST_I)
        SELF_POWERED_O |-> DEFAULT_CFG_EN_O || !CFG_VALID_O;
    endproperty
    a_local_power_detect: assert property (p_local_power_detect) else $error("self power outside default");

    property p_pwr_sample;
        @(posedge CLK_I) disable iff (!NRST_I)
        $rose(CFG_VALID_O) && DEFAULT_CFG_EN_O |-> SELF_POWERED_O == st_ff.straps.local_pwr;
    endproperty
    a_pwr_sample: assert property (p_pwr_sample) else $error("power status wrong");

    property p_extclk;
        @(posedge CLK_I) disable iff (!NRST_I)
        CFG_VALID_O |-> EXT_CLOCK_O == st_ff.straps.ext_clk;
    endproperty
    a_extclk: assert property (p_extclk) else $error("clock select wrong");

    property p_valid_hold;
        @(posedge CLK_I) disable iff (!NRST_I)
        $past(CFG_VALID_O) |-> CFG_VALID_O;
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("valid dropped");

    property p_reserved;
        @(posedge CLK_I) disable iff (!NRST_I)
        CFG_VALID_O |-> METHOD_RESERVED_O == (METHOD_O == 2'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved decode wrong");

    property p_addr;
        @(posedge CLK_I) disable iff (!NRST_I)
        CFG_VALID_O |-> SMB_ADDR_O == (SMBUS_SLAVE_EN_O ? 7'h2C : 7'h00);
    endproperty
    a_addr: assert property (p_addr) else $error("slave address wrong");

    property p_straps_frozen;
        @(posedge CLK_I) disable iff (!NRST_I)
        $past(CFG_VALID_O) & CFG_VALID_O |-> $stable(EXT_CLOCK_O) && $stable(SELF_POWERED_O);
    endproperty
    a_straps_frozen: assert property (p_straps_frozen) else $error("strap output moved");
endmodule
`default_nettype wire

// file: dv/hcs_strap_model.sv
// Board strap model driving the select, clock-select and power-detect pins
`timescale 1ns/10ps
`default_nettype none
module hcs_strap_model (
    input wire logic clk_i,                  // Bench clock
    input var hcs_pkg::hcs_straps_t want_i,  // Levels the board should present
    output logic sel_hi_o,                   // High select strap
    output logic scl_o,                      // Shared serial clock and low select line
    output logic ext_clk_o,                  // External clock select strap
    output logic local_pwr_o                 // Local power detect
);
    // Known levels from time zero, so the pins never float before the first edge
    initial
    begin
        sel_hi_o = 1'b0;
        scl_o = 1'b0;
        ext_clk_o = 1'b0;
        local_pwr_o = 1'b0;
    end

    always @(posedge clk_i)
    begin
        sel_hi_o <= want_i.sel_hi;
        scl_o <= want_i.sel_lo;
        ext_clk_o <= want_i.ext_clk;
        local_pwr_o <= want_i.local_pwr;
    end
endmodule
`default_nettype wire

// file: dv/hcs_top_tb.sv
// Self-checking testbench for the configuration strap selector
`timescale 1ns/10ps
`default_nettype none
module hcs_top_tb;
    logic clk;
    logic nrst_n;
    hcs_pkg::hcs_straps_t want;
    logic sel_hi, scl, ext, pwr;
    logic [1:0] method;
    logic [6:0] addr;
    logic valid, smb, dflt, eep, rsv, selfp, extc, sclo, rshort;
    int failures;
    int samples_checked;

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        nrst_n = 1'b0;
        want = '0;
        failures = 0;
        samples_checked = 0;
    end

    hcs_strap_model i_hcs_strap_model (.clk_i(clk), .want_i(want), .sel_hi_o(sel_hi),
        .scl_o(scl), .ext_clk_o(ext), .local_pwr_o(pwr));

    hcs_top i_hcs_top (.CLK_I(clk), .NRST_I(nrst_n), .SCL_I(scl),
        .CONFIG_METHOD_SEL_HI_I(sel_hi), .EXT_CLOCK_SELECT_I(ext),
        .LOCAL_POWER_DETECT_I(pwr), .METHOD_O(method), .CFG_VALID_O(valid),
        .SMBUS_SLAVE_EN_O(smb), .SMB_ADDR_O(addr), .DEFAULT_CFG_EN_O(dflt),
        .EEPROM_EN_O(eep), .METHOD_RESERVED_O(rsv), .SELF_POWERED_O(selfp),
        .EXT_CLOCK_O(extc), .SERIAL_SCL_O(sclo), .RST_TOO_SHORT_O(rshort));

    task automatic chk(input string name, input logic [6:0] exp, input logic [6:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("Counts: %0d checked, %0d mismatches", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Straps settle well before release so the sample edge sees them stable
    task automatic do_reset(input hcs_pkg::hcs_straps_t s);
        @(posedge clk);
        nrst_n <= 1'b0;
        want <= s;
        repeat (20) @(posedge clk);
        chk("valid_in_reset", 7'h00, {6'h00, valid});
        nrst_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic check_all(input logic [1:0] c, input logic p, input logic e);
        chk("method", {5'h00, c}, {5'h00, method});
        chk("valid", 7'h01, {6'h00, valid});
        chk("reserved", {6'h00, c == 2'h0}, {6'h00, rsv});
        chk("smbus", {6'h00, c == 2'h1}, {6'h00, smb});
        chk("addr", (c == 2'h1) ? 7'h2C : 7'h00, addr);
        chk("default", {6'h00, c == 2'h2}, {6'h00, dflt});
        chk("eeprom", {6'h00, c == 2'h3}, {6'h00, eep});
        chk("local_power_detect", {6'h00, c == 2'h2 && p}, {6'h00, selfp});
        chk("ext_clock", {6'h00, e}, {6'h00, extc});
        chk("serial_clk", {6'h00, c[0]}, {6'h00, sclo});
        chk("rst_short", 7'h00, {6'h00, rshort});
    endtask

    // Every select code with both power levels and both clock sources
    task automatic t_methods();
        logic [2:0] i;
        for (int k = 0; k < 8; k++)
        begin
            i = 3'(k);
            do_reset('{i[1], i[0], ~i[2], i[2]});
            check_all(i[1:0], i[2], ~i[2]);
        end
        $display("test methods done");
    endtask

    // Strap changes after sampling are ignored; the shared line keeps clocking in SMBus mode and is blocked in default mode
    task automatic t_hold();
        do_reset('{1'b0, 1'b1, 1'b0, 1'b1});
        @(posedge clk);
        want <= '{1'b1, 1'b0, 1'b1, 1'b0};
        repeat (5) @(posedge clk);
        #1;
        chk("method_held", 7'h01, {5'h00, method});
        chk("smbus_held", 7'h01, {6'h00, smb});
        chk("ext_held", 7'h00, {6'h00, extc});
        chk("serial_low", 7'h00, {6'h00, sclo});
        @(posedge clk);
        want <= '{1'b1, 1'b1, 1'b1, 1'b0};
        repeat (5) @(posedge clk);
        #1;
        chk("serial_high", 7'h01, {6'h00, sclo});
        do_reset('{1'b1, 1'b0, 1'b0, 1'b1});
        @(posedge clk);
        want <= '{1'b0, 1'b1, 1'b1, 1'b0};
        repeat (5) @(posedge clk);
        #1;
        chk("serial_blocked", 7'h00, {6'h00, sclo});
        chk("default_held", 7'h01, {6'h00, dflt});
        chk("self_held", 7'h01, {6'h00, selfp});
        $display("test hold done");
    endtask

    // About 300 cycles of tests; allow over three times that
    initial
    begin
        #100000;
        failures++;
        end_of_test();
    end

    initial
    begin
        t_methods();
        t_hold();
        end_of_test();
    end
endmodule
`default_nettype wire
